// File: rtl/status_regs_pkg.sv
package status_regs_pkg;

  // register offsets on the serial-bus register map
  localparam logic [7:0] STATUS_ADDR    = 8'h3A;
  localparam logic [7:0] OUT_CTRL_ADDR  = 8'h3B;
  localparam logic [7:0] SHARED_ADDR    = 8'h3C;
  localparam logic [7:0] SW_RESET_ADDR  = 8'h3D;

  // status_and_interrupt fields
  localparam int MASK_BUSY_BIT    = 6;
  localparam int STARTUP_BUSY_BIT = 5;
  localparam int ENGINE_BUSY_BIT  = 4;
  localparam int EXT_CLK_BIT      = 3;
  localparam int ENG1_BIT         = 2;
  localparam int ENG2_BIT         = 1;
  localparam int ENG3_BIT         = 0;
  localparam logic MASK_BUSY_RESET = 1'b1;

  // general_output_control fields
  localparam int PIN_SEL_BIT   = 2;
  localparam int AUX_LEVEL_BIT = 1;
  localparam int IRQ_LEVEL_BIT = 0;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h00;

  // shared variable and software reset
  localparam logic [7:0] SHARED_RESET   = 8'h00;
  localparam logic [7:0] SW_RESET_KEY   = 8'hFF;
  localparam logic [7:0] SW_RESET_READ  = 8'h03;

  // external clock detection window
  localparam int CLK_PERIOD_NS       = 25;
  localparam int EXT_CLK_TIMEOUT_NS  = 100000;
  localparam int EXT_CLK_TIMEOUT_CYC =
    (EXT_CLK_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
    EXT_CLK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int EXT_CNT_W = 12;

endpackage : status_regs_pkg

// File: rtl/ext_clock_detector.sv
`timescale 1ns/100ps
module ext_clock_detector
  import status_regs_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic clock_detect_enable,
  // external clock pin
  input  wire logic ext_clk_pin,
  // result
  output logic      ext_clock_seen_flag
);

  logic                 sync1_reg;
  logic                 sync2_reg;
  logic                 prev_reg;
  logic [EXT_CNT_W-1:0] cnt_reg;
  wire                  rise_seen;
  wire                  timed_out;

  assign rise_seen = sync2_reg & ~prev_reg;
  assign timed_out =
    (cnt_reg == EXT_CNT_W'(EXT_CLK_TIMEOUT_CYC - 1));

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    sync1_reg <= ext_clk_pin;
    sync2_reg <= sync1_reg;
    prev_reg  <= sync2_reg;
  end

  ///////////////////////////////////////////////////////////////////////////
  // flag only moves while detection is enabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg             <= '0;
      ext_clock_seen_flag <= 1'b0;
    end
    else if (!clock_detect_enable)
      cnt_reg <= '0;
    else if (rise_seen)
    begin
      cnt_reg             <= '0;
      ext_clock_seen_flag <= 1'b1;
    end
    else if (timed_out)
    begin
      cnt_reg             <= '0;
      ext_clock_seen_flag <= 1'b0;
    end
    else
      cnt_reg <= cnt_reg + EXT_CNT_W'(1);
  end

endmodule : ext_clock_detector

// File: rtl/status_irq_gpo_reset_regs.sv
`timescale 1ns/100ps
module status_irq_gpo_reset_regs
  import status_regs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register access from the serial-bus front end
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // engine and core status
  input  wire logic [2:0] engine_irq_event,
  input  wire logic       startup_busy,
  input  wire logic       engine_busy,
  input  wire logic       clock_detect_enable,
  input  wire logic       ext_clk_pin,
  // pins
  output logic            irq_pin_o,
  output logic            irq_pin_oe,
  output logic            aux_output_pin,
  // chip-wide software reset
  output logic            sw_reset_pulse
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  logic       core_rst;
  logic [2:0] eng_flag_reg;
  logic [1:0] busy_evt_reg;
  logic [1:0] busy_prev_reg;
  logic       mask_busy_reg;
  logic [7:0] out_ctrl_reg;
  logic [7:0] shared_reg;
  logic       sw_rst_reg;
  logic       ext_clock_seen_flag;
  wire        status_rd;
  wire        wr_status;
  wire        wr_out_ctrl;
  wire        wr_shared;
  wire        wr_sw_reset;
  wire  [1:0] busy_now;
  wire  [1:0] busy_fall;
  wire  [7:0] status_view;
  wire  [7:0] rd_mux;
  wire        irq_pin_function_sel;
  wire        irq_pin_level;
  wire        irq_active;

  assign core_rst    = rst | sw_rst_reg;
  assign status_rd   = reg_rd & hit(reg_addr, STATUS_ADDR);
  assign wr_status   = reg_wr & hit(reg_addr, STATUS_ADDR);
  assign wr_out_ctrl = reg_wr & hit(reg_addr, OUT_CTRL_ADDR);
  assign wr_shared   = reg_wr & hit(reg_addr, SHARED_ADDR);
  assign wr_sw_reset = reg_wr & hit(reg_addr, SW_RESET_ADDR);
  assign sw_reset_pulse = sw_rst_reg;

  ///////////////////////////////////////////////////////////////////////////
  // engine flags: a new event beats the read clear
  for (genvar i = 0; i < 3; i++)
  begin : g_eng
    always_ff @(posedge clk)
    begin
      if (core_rst)
        eng_flag_reg[i] <= 1'b0;
      else if (engine_irq_event[i])
        eng_flag_reg[i] <= 1'b1;
      else if (status_rd)
        eng_flag_reg[i] <= 1'b0;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // busy-end events, gated by the mask
  assign busy_now  = {startup_busy, engine_busy};
  assign busy_fall = busy_prev_reg & ~busy_now;

  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      busy_prev_reg <= 2'h0;
      busy_evt_reg  <= 2'h0;
      mask_busy_reg <= MASK_BUSY_RESET;
    end
    else
    begin
      busy_prev_reg <= busy_now;
      if (wr_status)
        mask_busy_reg <= reg_wdata[MASK_BUSY_BIT];
      if (!mask_busy_reg && (busy_fall != 2'h0))
        busy_evt_reg <= busy_evt_reg | busy_fall;
      else if (status_rd || mask_busy_reg)
        busy_evt_reg <= 2'h0;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      out_ctrl_reg <= OUT_CTRL_RESET;
      shared_reg   <= SHARED_RESET;
    end
    else
    begin
      if (wr_out_ctrl)
        out_ctrl_reg <= reg_wdata & 8'h07;
      if (wr_shared)
        shared_reg <= reg_wdata;
    end
  end

  // only the hard reset resets the self-reset strobe; the !sw_rst_reg term keeps it to one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      sw_rst_reg <= 1'b0;
    else
      sw_rst_reg <= wr_sw_reset && (reg_wdata == SW_RESET_KEY) &&
                    !sw_rst_reg;
  end

  ext_clock_detector u_det (
    .clk                 (clk),
    .rst                 (core_rst),
    .clock_detect_enable (clock_detect_enable),
    .ext_clk_pin         (ext_clk_pin),
    .ext_clock_seen_flag (ext_clock_seen_flag)
  );

  ///////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the strobe
  assign status_view = {1'b0, mask_busy_reg,
                        busy_now | busy_evt_reg,
                        ext_clock_seen_flag,
                        eng_flag_reg};
  assign rd_mux =
    hit(reg_addr, STATUS_ADDR)   ? status_view :
    hit(reg_addr, OUT_CTRL_ADDR) ? out_ctrl_reg :
    hit(reg_addr, SHARED_ADDR)   ? shared_reg :
    hit(reg_addr, SW_RESET_ADDR) ? SW_RESET_READ :
    8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  ///////////////////////////////////////////////////////////////////////////
  // pins; output role drives both levels, interrupt role only pulls low
  assign irq_pin_function_sel = out_ctrl_reg[PIN_SEL_BIT];
  assign irq_pin_level        = out_ctrl_reg[IRQ_LEVEL_BIT];
  assign irq_active = (eng_flag_reg != 3'h0) || (busy_evt_reg != 2'h0);
  assign irq_pin_o  = irq_pin_function_sel & irq_pin_level;
  assign irq_pin_oe = irq_pin_function_sel | irq_active;
  assign aux_output_pin = out_ctrl_reg[AUX_LEVEL_BIT];

  ///////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (core_rst);

  sequence s_status_read;
    reg_rd && (reg_addr == STATUS_ADDR);
  endsequence
  sequence s_key_write;
    reg_wr && (reg_addr == SW_RESET_ADDR) && (reg_wdata == SW_RESET_KEY);
  endsequence

  a_engine_flag_set: assert property (
    engine_irq_event[0] |=> eng_flag_reg[0])
    else $error("engine flag not set by event");
  a_flag_read_clear: assert property (
    (s_status_read and !engine_irq_event[0]) |=> !eng_flag_reg[0])
    else $error("engine flag not cleared by status read");
  a_flag_event_kept: assert property (
    (s_status_read and engine_irq_event[1]) |=> eng_flag_reg[1] ##1
    (eng_flag_reg[1] || $past(status_rd)))
    else $error("engine event lost during read");
  a_irq_pin_pull: assert property (
    (!irq_pin_function_sel && eng_flag_reg != 3'h0) |->
    (irq_pin_oe && !irq_pin_o))
    else $error("irq pin not pulled low");
  a_irq_open_drain: assert property (
    !irq_pin_function_sel |-> !irq_pin_o)
    else $error("irq pin driven high in interrupt role");
  a_irq_idle_release: assert property (
    (!irq_pin_function_sel && !irq_active) |-> !irq_pin_oe)
    else $error("irq pin not released when idle");
  a_pin_level_mode: assert property (
    (reg_wr && reg_addr == OUT_CTRL_ADDR && reg_wdata[2]) |=>
    irq_pin_oe && (irq_pin_o == $past(reg_wdata[0])))
    else $error("irq pin level wrong in output role");
  a_aux_follow: assert property (
    (reg_wr && reg_addr == OUT_CTRL_ADDR) |=>
    aux_output_pin == $past(reg_wdata[1]))
    else $error("aux output does not follow write");
  a_shared_write: assert property (
    wr_shared |=> shared_reg == $past(reg_wdata))
    else $error("shared variable not stored");
  a_reset_readback: assert property (
    (reg_rd && reg_addr == SW_RESET_ADDR) |=> reg_rdata == SW_RESET_READ)
    else $error("software reset register read wrong");
  a_soft_reset_key: assert property (@(posedge clk) disable iff (rst)
    (s_key_write and !sw_rst_reg) |=> sw_rst_reg ##1
    (!sw_rst_reg && shared_reg == SHARED_RESET && !mask_busy_reg == 1'b0))
    else $error("key write did not reset registers");
  a_busy_read_clear: assert property (
    (s_status_read and busy_fall == 2'h0) |=> busy_evt_reg == 2'h0)
    else $error("busy events not cleared by read");
  a_ext_flag_hold: assert property (
    !clock_detect_enable |=> $stable(ext_clock_seen_flag))
    else $error("clock flag moved while detection off");

endmodule : status_irq_gpo_reset_regs

// File: sim/host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
module host_model
(
  // clock
  input  wire logic       clk,
  // byte register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // irq pin with board pull-up
  input  wire logic       irq_pin_o,
  input  wire logic       irq_pin_oe,
  output logic            irq_wire
);
  // a released pin is pulled up, never left floating
  assign irq_wire = irq_pin_oe ? irq_pin_o : 1'b1;
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #2;
    reg_wr    = 1'b0;
    // stale data would hide a late sample
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #2;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd
endmodule : host_model

// File: sim/tb_status_irq_gpo_reset_regs.sv
`timescale 1ns/100ps
module tb_status_irq_gpo_reset_regs
  import status_regs_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, v;
  logic       reg_wr, reg_rd, irq_pin_o, irq_pin_oe, irq_wire;
  logic [2:0] engine_irq_event = 3'h0;
  logic       engine_busy = 1'b0;
  logic       startup_busy = 1'b0;
  logic       clock_detect_enable = 1'b0;
  logic       ext_clk_pin = 1'b0;
  logic       aux_output_pin, sw_reset_pulse;
  int         seed = 78;
  int         error_cnt = 0;
  int         checked = 0;
////////////////////////////////////////
  always #12.5 clk = ~clk;
  status_irq_gpo_reset_regs u_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .engine_irq_event(engine_irq_event), .startup_busy(startup_busy),
    .engine_busy(engine_busy), .clock_detect_enable(clock_detect_enable),
    .ext_clk_pin(ext_clk_pin), .irq_pin_o(irq_pin_o),
    .irq_pin_oe(irq_pin_oe), .aux_output_pin(aux_output_pin),
    .sw_reset_pulse(sw_reset_pulse));
  host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .irq_wire(irq_wire));
////////////////////////////////////////
  // pin level with no flag pending
  function automatic logic [7:0] idle_pin(input logic [7:0] c);
    return {7'h00, c[PIN_SEL_BIT] ? c[IRQ_LEVEL_BIT] : 1'b1};
  endfunction : idle_pin
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    #2;
    engine_irq_event = e;
    @(posedge clk);
    #2;
    engine_irq_event = 3'h0;
  endtask : ev
  task automatic toggle_ext;
    repeat (8)
    begin
      @(posedge clk);
      #2;
      ext_clk_pin = ~ext_clk_pin;
    end
  endtask : toggle_ext
  // busy levels rise for one cycle, then two edges let the event land
  task automatic busy_pulse(input logic [1:0] b);
    @(posedge clk);
    #2;
    {startup_busy, engine_busy} = b;
    @(posedge clk);
    #2;
    {startup_busy, engine_busy} = 2'b00;
    repeat (2) @(posedge clk);
    #2;
  endtask : busy_pulse
  // tests take about 4200 cycles, mostly the clock-loss wait
  initial
  begin
    #250000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h40);
    u_host.rd(OUT_CTRL_ADDR, rv);
    chk(rv, 8'h00);
    u_host.rd(SHARED_ADDR, rv);
    chk(rv, 8'h00);
    u_host.rd(SW_RESET_ADDR, rv);
    chk(rv, 8'h03);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'h04 : (i == 1) ? 8'h05 : 8'($random(seed));
      u_host.wr(OUT_CTRL_ADDR, v);
      chk({7'h00, irq_pin_oe}, {7'h00, v[2]});
      chk({7'h00, irq_wire}, idle_pin(v));
      chk({7'h00, aux_output_pin}, {7'h00, v[1]});
      u_host.rd(OUT_CTRL_ADDR, rv);
      chk(rv, v & 8'h07);
      u_host.wr(SHARED_ADDR, ~v);
      u_host.rd(SHARED_ADDR, rv);
      chk(rv, ~v);
    end
    u_host.wr(OUT_CTRL_ADDR, 8'h00);
    $display("output test done");
    for (int k = 0; k < 4; k++)
    begin
      v = (k == 3) ? 8'h05 : 8'h04 >> k;
      ev(v[2:0]);
      chk({7'h00, irq_wire}, 8'h00);
      u_host.rd(STATUS_ADDR, rv);
      chk(rv, 8'h40 | v);
      u_host.rd(STATUS_ADDR, rv);
      chk(rv, 8'h40);
      chk({7'h00, irq_wire}, 8'h01);
    end
    fork
      u_host.rd(STATUS_ADDR, rv);
      ev(3'b010);
    join
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h42);
    $display("flag test done");
    busy_pulse(2'b11);
    chk({7'h00, irq_wire}, 8'h01);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h40);
    u_host.wr(STATUS_ADDR, 8'h00);
    busy_pulse(2'b01);
    chk({7'h00, irq_wire}, 8'h00);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h10);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h00);
    chk({7'h00, irq_wire}, 8'h01);
    busy_pulse(2'b10);
    chk({7'h00, irq_wire}, 8'h00);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h20);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h00);
    chk({7'h00, irq_wire}, 8'h01);
    toggle_ext();
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h00);
    clock_detect_enable = 1'b1;
    toggle_ext();
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h08);
    // flag holds just short of the loss window, then drops
    repeat (EXT_CLK_TIMEOUT_CYC - 20) @(posedge clk);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h08);
    repeat (30) @(posedge clk);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h00);
    $display("busy and clock test done");
    u_host.wr(SHARED_ADDR, 8'hA5);
    u_host.wr(SW_RESET_ADDR, 8'hFE);
    chk({7'h00, sw_reset_pulse}, 8'h00);
    u_host.rd(SW_RESET_ADDR, rv);
    chk(rv, 8'h03);
    u_host.rd(SHARED_ADDR, rv);
    chk(rv, 8'hA5);
    u_host.wr(OUT_CTRL_ADDR, 8'h07);
    u_host.wr(SW_RESET_ADDR, SW_RESET_KEY);
    chk({7'h00, sw_reset_pulse}, 8'h01);
    @(posedge clk);
    u_host.rd(SHARED_ADDR, rv);
    chk(rv, 8'h00);
    u_host.rd(OUT_CTRL_ADDR, rv);
    chk(rv, 8'h00);
    u_host.rd(STATUS_ADDR, rv);
    chk(rv, 8'h40);
    $display("soft reset test done");
    stop_test();
  end
endmodule : tb_status_irq_gpo_reset_regs
